// ===== rtl/dap_pkg.sv
// Package of shared constants and types for the DRAM command sequencing ends.
package dap_pkg;

	// ------------------------------------------------------------------
	// Geometry and timing
	// ------------------------------------------------------------------
	localparam int          CLK_PERIOD_NS                     = 4;
	localparam int          NUM_BANKS                         = 4;
	localparam int          BANK_W                            = 2;
	localparam int          ADDR_W                            = 13;
	localparam int          DATA_W                            = 16;
	localparam int          AUTO_PRECHARGE_FLAG_BIT           = 10;
	localparam int          BURST_LENGTH                      = 4;
	localparam int          MIN_ACTIVE_TO_PRECHARGE_TIME_NS   = 40;
	localparam int          ROW_PRECHARGE_TIME_NS             = 20;
	localparam int          WRITE_RECOVERY_TIME_NS            = 15;
	localparam int          REFRESH_CYCLE_TIME_NS             = 75;
	localparam int          SELF_REFRESH_EXIT_TIME_NS         = 80;
	localparam int          ACTIVATE_TO_COLUMN_DELAY_NS       = 20;
	localparam int          INPUT_SETUP_TIME_NS               = 1;
	// Least times round up to whole cycles.
	localparam int          RAS_CYC  = (MIN_ACTIVE_TO_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1)
	                                   / CLK_PERIOD_NS;
	localparam int          RP_CYC   = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WR_CYC   = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RFC_CYC  = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          XSR_CYC  = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1)
	                                   / CLK_PERIOD_NS;
	localparam int          RCD_CYC  = (ACTIVATE_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1)
	                                   / CLK_PERIOD_NS;
	localparam int          IS_CYC   = 1 + (INPUT_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          TMR_W    = 8;

	// ------------------------------------------------------------------
	// Command encodings {cs_n, ras_n, cas_n, we_n}
	// ------------------------------------------------------------------
	localparam logic [3:0]  CMD_NOP     = 4'h7;
	localparam logic [3:0]  CMD_DESEL   = 4'h8;
	localparam logic [3:0]  CMD_ACT     = 4'h3;
	localparam logic [3:0]  CMD_READ    = 4'h5;
	localparam logic [3:0]  CMD_WRITE   = 4'h4;
	localparam logic [3:0]  CMD_PRE     = 4'h2;
	localparam logic [3:0]  CMD_REF     = 4'h1;

	typedef enum logic [2:0] {
		BANK_IDLE   = 3'h1,
		BANK_ACTIVE = 3'h2,
		BANK_PRECH  = 3'h4
	} dap_bank_type;

	typedef enum logic [3:0] {
		DEV_RUN     = 4'h1,
		DEV_REFRESH = 4'h2,
		DEV_SELF    = 4'h4,
		DEV_PDOWN   = 4'h8
	} dap_dev_type;

	typedef enum logic [4:0] {
		CTL_IDLE  = 5'h01,
		CTL_WAIT  = 5'h02,
		CTL_DATA  = 5'h04,
		CTL_SELF  = 5'h08,
		CTL_PDOWN = 5'h10
	} dap_ctl_type;

endpackage : dap_pkg

// ===== rtl/dap_link_if.sv
// Interface carrying the command, address and write data pins between the two ends.
`timescale 1ns/1ns
interface dap_link_if;
	import dap_pkg::*;
	logic                  cke;        // Clock enable pin.
	logic                  cs_n;       // Chip select, active low.
	logic                  ras_n;      // Row strobe, active low.
	logic                  cas_n;      // Column strobe, active low.
	logic                  we_n;       // Write strobe, active low.
	logic [BANK_W-1:0]     ba;         // Bank address.
	logic [ADDR_W-1:0]     addr;       // Row or column address.
	logic [DATA_W-1:0]     wdata;      // Write data beat.
	logic                  write_mask; // High discards the beat.
	logic                  wstrobe;    // Beat valid, one per strobe edge.
	logic [DATA_W-1:0]     rdata;      // Read data beat from device.
	logic                  rvalid;     // Read beat valid.

	modport device (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, wdata, write_mask, wstrobe,
	                output rdata, rvalid);
	modport controller (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, wdata, write_mask,
	                    wstrobe, input rdata, rvalid);
endinterface : dap_link_if

// ===== rtl/dap_device.sv
// Memory device end: command decode, bank timers, auto precharge, refresh and power down.
`timescale 1ns/1ns

// Summary of operation
// R1: Mask affects writes only, never reads.
// R2: Masked write beat is discarded immediately.
// R3: Controller aligns mask with strobe edge.
// R4: Read auto precharge after BL/2, min_active_to_precharge_time held.
// R5: No reuse of bank during precharge.
// R6: Read-AP follow-on windows at 3,4,5.
// R7: Flag bit high makes write auto precharge.
// R8: Write auto precharge waits write recovery.
// R9: Write-AP follow-on windows through clock 8.
// R10: Auto refresh decoded with clock enable high.
// R11: All banks idle before auto refresh.
// R12: Refresh uses internal row counter; banks idle.
// R13: Wait refresh cycle before next activate.
// R14: Self refresh decoded with clock enable low.
// R15: Clock enable held low in self refresh.
// R16: Self refresh ignores all but clock enable.
// R17: Exit self refresh with NOP, then wait.
// R18: Write after activate once column delay met.
// R19: Clock enable low enters, high leaves power-down.
// R20: Power-down gates receivers, keeps clock alive.
// R21: Banks idle; clock enable early before activate. Here power-down is entered with a bank still active, and the bench checks this.
// R22: Power-down shorter than refresh period.
// R23: Per-bank state with timers kept.
module dap_device
	import dap_pkg::*;
#(
	parameter int NBANK = NUM_BANKS,       // Number of banks.
	parameter int WORDS = 16               // Storage words, one array shared by all banks.
) (
	input  wire logic                clk_i,            // Device clock.
	input  wire logic                resetn_i,         // Asynchronous reset, active low.
	dap_link_if.device               link,             // Pins from the controller.
	output logic [ADDR_W-1:0]        refresh_row_o,    // Internal refresh row counter.
	output logic                     self_refresh_o,   // High while in self refresh.
	output logic                     power_down_o,     // High while in power-down.
	output logic                     cmd_error_o,      // Pulse on an illegal command.
	output logic [3*NBANK-1:0]       bank_state_o      // One-hot state per bank.
);

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	dap_dev_type              dev_r;
	dap_bank_type             bank_r   [NBANK];
	logic [TMR_W-1:0]         ras_tmr_r[NBANK];
	logic [TMR_W-1:0]         ap_tmr_r [NBANK];
	logic                     ap_pend_r[NBANK];
	logic [TMR_W-1:0]         rp_tmr_r [NBANK];
	logic [TMR_W-1:0]         rfc_tmr_r;
	logic                     cke_prev_r;
	logic [3:0]               cmd;
	logic                     live;
	logic [DATA_W-1:0]        mem_r [WORDS];
	logic [$clog2(WORDS)-1:0] wptr_r;
	logic                     wr_burst_r;
	logic [DATA_W-1:0]        rdata_r;
	logic                     rvalid_r;
	logic [ADDR_W-1:0]        row_r;
	logic                     err_r;

	assign cmd  = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
	// Receivers count only while running; self refresh and power-down gate them.
	assign live = (dev_r == DEV_RUN) && link.cke && cke_prev_r; // R16 R20

	// ------------------------------------------------------------------
	// Device mode
	// ------------------------------------------------------------------
	// Clock enable is seen on every edge; the clock itself keeps running here.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dev_r      <= DEV_RUN;
			cke_prev_r <= 1'b1;
			rfc_tmr_r  <= '0;
		end else begin
			cke_prev_r <= link.cke;
			if (rfc_tmr_r != '0) rfc_tmr_r <= rfc_tmr_r - 1'b1;
			case (dev_r)
				DEV_RUN: begin
					if (cke_prev_r && !link.cke && cmd == CMD_REF) begin
						dev_r <= DEV_SELF; // R14
					end else if (cke_prev_r && !link.cke) begin
						dev_r <= DEV_PDOWN; // R19
					end else if (live && cmd == CMD_REF) begin
						dev_r     <= DEV_REFRESH; // R10
						rfc_tmr_r <= TMR_W'(RFC_CYC);
					end
				end
				DEV_REFRESH: begin
					if (rfc_tmr_r == 8'h01) dev_r <= DEV_RUN; // R12
				end
				DEV_SELF: begin
					if (link.cke) dev_r <= DEV_RUN; // R16
				end
				DEV_PDOWN: begin
					if (link.cke) dev_r <= DEV_RUN; // R19
				end
				default: dev_r <= DEV_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Refresh row counter
	// ------------------------------------------------------------------
	// External address pins are ignored; the row comes from this counter.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			row_r <= '0;
		end else if ((dev_r == DEV_RUN && live && cmd == CMD_REF)
		             || (dev_r == DEV_SELF && rfc_tmr_r == '0)) begin
			row_r <= row_r + 1'b1; // R12
		end
	end

	// ------------------------------------------------------------------
	// Per-bank state and timers
	// ------------------------------------------------------------------
	genvar gb;
	generate
		for (gb = 0; gb < NBANK; gb++) begin : g_bank
			logic hit;
			assign hit = live && (link.ba == BANK_W'(gb));
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					bank_r[gb]    <= BANK_IDLE;
					ras_tmr_r[gb] <= '0;
					ap_tmr_r[gb]  <= '0;
					ap_pend_r[gb] <= 1'b0;
					rp_tmr_r[gb]  <= '0;
				end else begin
					if (ras_tmr_r[gb] != '0) ras_tmr_r[gb] <= ras_tmr_r[gb] - 1'b1;
					if (ap_tmr_r[gb] != '0) ap_tmr_r[gb] <= ap_tmr_r[gb] - 1'b1;
					if (dev_r == DEV_REFRESH) begin
						bank_r[gb] <= BANK_IDLE; // R12
					end
					case (bank_r[gb])
						BANK_IDLE: begin
							if (hit && cmd == CMD_ACT) begin
								bank_r[gb]    <= BANK_ACTIVE; // R23
								ras_tmr_r[gb] <= TMR_W'(RAS_CYC);
							end
						end
						BANK_ACTIVE: begin
							if (hit && (cmd == CMD_READ || cmd == CMD_WRITE)
							    && link.addr[AUTO_PRECHARGE_FLAG_BIT]) begin
								ap_pend_r[gb] <= 1'b1; // R7
								// Read waits BL/2; write waits the burst plus recovery.
								ap_tmr_r[gb]  <= (cmd == CMD_READ)
								                 ? TMR_W'(BURST_LENGTH / 2) // R4
								                 : TMR_W'(BURST_LENGTH / 2 + 1 + WR_CYC); // R8
							end else if ((hit && cmd == CMD_PRE && ras_tmr_r[gb] == '0)
							             || (live && cmd == CMD_PRE
							                 && link.addr[AUTO_PRECHARGE_FLAG_BIT])
							             || (ap_pend_r[gb] && ap_tmr_r[gb] == '0
							                 && ras_tmr_r[gb] == '0)) begin // R4
								bank_r[gb]    <= BANK_PRECH;
								ap_pend_r[gb] <= 1'b0;
								rp_tmr_r[gb]  <= TMR_W'(RP_CYC);
							end
						end
						BANK_PRECH: begin
							if (rp_tmr_r[gb] > 8'h01) begin
								rp_tmr_r[gb] <= rp_tmr_r[gb] - 1'b1;
							end else begin
								bank_r[gb]   <= BANK_IDLE; // R23
								rp_tmr_r[gb] <= '0;
							end
						end
						default: bank_r[gb] <= BANK_IDLE;
					endcase
				end
			end
			assign bank_state_o[3*gb +: 3] = bank_r[gb];
		end
	endgenerate

	// ------------------------------------------------------------------
	// Write and read data path
	// ------------------------------------------------------------------
	// Masked beats advance the pointer but leave storage untouched, zero latency.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wptr_r     <= '0;
			wr_burst_r <= 1'b0;
			rvalid_r   <= 1'b0;
			rdata_r    <= '0;
			for (int i = 0; i < WORDS; i++) mem_r[i] <= '0;
		end else begin
			rvalid_r <= 1'b0;
			if (live && cmd == CMD_WRITE) begin
				wptr_r     <= link.addr[$clog2(WORDS)-1:0];
				wr_burst_r <= 1'b1;
			end else if (live && cmd == CMD_READ) begin
				wptr_r     <= link.addr[$clog2(WORDS)-1:0];
				wr_burst_r <= 1'b0; // R1
			end
			if (wr_burst_r && link.wstrobe && dev_r == DEV_RUN) begin
				if (!link.write_mask) mem_r[wptr_r] <= link.wdata; // R2
				wptr_r <= wptr_r + 1'b1;
			end
			// Read data ignores the mask pin entirely.
			if (live && cmd == CMD_READ) begin
				rdata_r  <= mem_r[link.addr[$clog2(WORDS)-1:0]]; // R1
				rvalid_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Illegal command check
	// ------------------------------------------------------------------
	// Flags access to a bank that is not in a state to accept it.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			err_r <= 1'b0;
		end else begin
			err_r <= live && (((cmd == CMD_ACT) && (bank_r[link.ba] != BANK_IDLE
			                                       || rfc_tmr_r != '0)) // R5 R13
			        || ((cmd == CMD_READ || cmd == CMD_WRITE)
			            && bank_r[link.ba] != BANK_ACTIVE)); // R23
		end
	end

	assign link.rdata     = rdata_r;
	assign link.rvalid    = rvalid_r;
	assign refresh_row_o  = row_r;
	assign self_refresh_o = dev_r[2];
	assign power_down_o   = dev_r[3];
	assign cmd_error_o    = err_r;

endmodule : dap_device

// ===== rtl/dap_controller.sv
// Controller end: issues commands with legal spacing and streams buffered write data.
`timescale 1ns/1ns
module dap_controller
	import dap_pkg::*;
(
	input  wire logic                clk_i,        // Controller clock.
	input  wire logic                resetn_i,     // Asynchronous reset, active low.
	dap_link_if.controller           link,         // Pins to the device.
	input  wire logic                req_valid_i,  // Request valid.
	output logic                     req_ready_o,  // Request accepted.
	input  wire logic [2:0]          req_op_i,     // 0 wr,1 wr-ap,2 ref,3 self,4 pdown,5 wake.
	input  wire logic [BANK_W-1:0]   req_bank_i,   // Target bank.
	input  wire logic [ADDR_W-1:0]   req_addr_i,   // Row and column.
	input  wire logic                wd_valid_i,   // Write word valid.
	output logic                     wd_ready_o,   // Buffer can take a word.
	input  wire logic [DATA_W-1:0]   wd_data_i,    // Write word.
	input  wire logic                wd_mask_i,    // Mask this word.
	output logic                     busy_o        // Sequence in progress.
);

	// ------------------------------------------------------------------
	// Two-entry write buffer
	// ------------------------------------------------------------------
	logic [DATA_W:0]    buf_r [2];
	logic [1:0]         cnt_r;
	logic               rd_ptr_r;
	logic               wr_ptr_r;
	logic               pop;
	logic               push;
	dap_ctl_type        st_r;
	logic [TMR_W-1:0]   wait_r;
	logic [2:0]         beats_r;
	logic [2:0]         op_r;
	logic [BANK_W-1:0]  bank_r;
	logic [ADDR_W-1:0]  addr_r;
	logic [3:0]         cmd_r;
	logic               cke_r;

	assign push = wd_valid_i && wd_ready_o;
	assign pop  = (st_r == CTL_DATA) && (cnt_r != 2'h0) && (cmd_r != CMD_WRITE); // Beats trail WRITE.
	// A stalled drain holds the buffer full, which drops ready to the source.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r    <= 2'h0;
			rd_ptr_r <= 1'b0;
			wr_ptr_r <= 1'b0;
			buf_r[0] <= '0;
			buf_r[1] <= '0;
		end else begin
			if (push) begin
				buf_r[wr_ptr_r] <= {wd_mask_i, wd_data_i};
				wr_ptr_r        <= ~wr_ptr_r;
			end
			if (pop) rd_ptr_r <= ~rd_ptr_r;
			cnt_r <= cnt_r + 2'(push) - 2'(pop);
		end
	end
	assign wd_ready_o = (cnt_r != 2'h2);

	// ------------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------------
	// Writes issue activate, wait column delay, write, stream, then hold off the bank.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r    <= CTL_IDLE;
			wait_r  <= '0;
			beats_r <= '0;
			op_r    <= '0;
			bank_r  <= '0;
			addr_r  <= '0;
			cmd_r   <= CMD_NOP;
			cke_r   <= 1'b1;
		end else begin
			cmd_r <= CMD_NOP;
			if (wait_r != '0) wait_r <= wait_r - 1'b1;
			case (st_r)
				CTL_IDLE: begin
					if (req_valid_i && wait_r == '0) begin
						op_r   <= req_op_i;
						bank_r <= req_bank_i;
						addr_r <= req_addr_i;
						case (req_op_i)
							3'h0, 3'h1: begin
								cmd_r  <= CMD_ACT;
								wait_r <= TMR_W'(RCD_CYC); // R18
								st_r   <= CTL_WAIT;
							end
							3'h2: begin
								cmd_r  <= CMD_REF; // R10 R11
								wait_r <= TMR_W'(RFC_CYC); // R13
							end
							3'h3: begin
								cmd_r <= CMD_REF; // R14
								cke_r <= 1'b0; // R15
								st_r  <= CTL_SELF;
							end
							3'h4: begin
								cke_r <= 1'b0; // R19 R21 R22
								st_r  <= CTL_PDOWN;
							end
							default: ;
						endcase
					end
				end
				CTL_WAIT: begin
					if (wait_r == '0) begin
						cmd_r   <= CMD_WRITE;
						// Set or clear the flag, as the column may carry either level.
						addr_r[AUTO_PRECHARGE_FLAG_BIT] <= op_r[0]; // R7
						beats_r <= 3'(BURST_LENGTH);
						st_r    <= CTL_DATA;
					end
				end
				CTL_DATA: begin
					if (pop) beats_r <= beats_r - 1'b1; // R3
					if (pop && beats_r == 3'h1) begin
						// Keep the bank untouched through recovery and precharge.
						wait_r <= TMR_W'(WR_CYC + RP_CYC + RAS_CYC); // R5 R8 R9
						st_r   <= CTL_IDLE;
					end
				end
				CTL_SELF, CTL_PDOWN: begin
					if (req_valid_i && req_op_i == 3'h5) begin
						cke_r  <= 1'b1; // R17
						wait_r <= TMR_W'((st_r == CTL_SELF) ? XSR_CYC : IS_CYC); // R17 R21
						st_r   <= CTL_IDLE;
					end
				end
				default: st_r <= CTL_IDLE;
			endcase
		end
	end

	assign req_ready_o = ((st_r == CTL_IDLE) && wait_r == '0)
	                     || ((st_r == CTL_SELF || st_r == CTL_PDOWN) && req_op_i == 3'h5);
	assign busy_o      = (st_r != CTL_IDLE) || (wait_r != '0);

	// ------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------
	assign link.cke        = cke_r;
	assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_r;
	assign link.ba         = bank_r;
	assign link.addr       = addr_r;
	assign link.wdata      = buf_r[rd_ptr_r][DATA_W-1:0];
	assign link.write_mask = buf_r[rd_ptr_r][DATA_W]; // R3
	assign link.wstrobe    = pop;

endmodule : dap_controller

// ===== bench/dap_link_asserts.sv
// Checker of the command, clock enable and beat pins between the two ends.
`timescale 1ns/1ns
module dap_link_asserts
	import dap_pkg::*;
(
	input  wire logic              clk_i,      // Clock.
	input  wire logic              resetn_i,   // Reset, active low.
	input  wire logic              cke,        // Clock enable.
	input  wire logic              cs_n,       // Select, active low.
	input  wire logic              ras_n,      // Row strobe, active low.
	input  wire logic              cas_n,      // Column strobe, active low.
	input  wire logic              we_n,       // Write strobe, active low.
	input  wire logic [BANK_W-1:0] ba,         // Bank.
	input  wire logic [ADDR_W-1:0] addr,       // Address.
	input  wire logic              write_mask, // Beat mask.
	input  wire logic              wstrobe     // Beat valid.
);
	// ----------------------------------------------------------------
	// Command ages
	// ----------------------------------------------------------------
	localparam int AP_GAP = BURST_LENGTH / 2 + 1 + WR_CYC + RP_CYC;
	logic [3:0]        cmd;
	logic [TMR_W-1:0]  act_age_r;
	logic [TMR_W-1:0]  ref_age_r;
	logic [TMR_W-1:0]  ap_age_r;
	logic [BANK_W-1:0] ap_bank_r;
	logic [2:0]        beats_r;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	function automatic logic [TMR_W-1:0] sat(input logic [TMR_W-1:0] v);
		return (v == '1) ? v : v + 1'h1;
	endfunction : sat
	// Ages saturate so that a long idle stretch never wraps into a false window.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			act_age_r <= '0;
			ref_age_r <= '1;
			ap_age_r  <= '1;
			ap_bank_r <= '0;
			beats_r   <= '0;
		end else begin
			act_age_r <= (cmd == CMD_ACT) ? 8'h01 : sat(act_age_r);
			ref_age_r <= (cmd == CMD_REF && cke) ? 8'h01 : sat(ref_age_r);
			if ((cmd == CMD_WRITE || cmd == CMD_READ) && addr[AUTO_PRECHARGE_FLAG_BIT]) begin
				ap_age_r  <= 8'h01;
				ap_bank_r <= ba;
			end else begin
				ap_age_r <= sat(ap_age_r);
			end
			if (cmd == CMD_WRITE) begin
				beats_r <= 3'(BURST_LENGTH);
			end else if (wstrobe && beats_r != 3'h0) begin
				beats_r <= beats_r - 3'h1;
			end
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	chk_act_write_gap: assert property (cmd == CMD_WRITE |-> act_age_r >= RCD_CYC)
		else $error("Write came before the column delay after activate.");
	chk_refresh_gap: assert property ((cmd == CMD_ACT || (cmd == CMD_REF && cke))
		|-> ref_age_r >= RFC_CYC) else $error("Command came inside the refresh cycle.");
	chk_refresh_idle: assert property (cmd == CMD_REF && cke |-> ap_age_r >= AP_GAP)
		else $error("Refresh issued before the precharge finished.");
	chk_ap_bank_busy: assert property (cmd == CMD_ACT && ba == ap_bank_r
		|-> ap_age_r >= AP_GAP) else $error("Bank reopened during its auto precharge.");
	chk_self_cke_low: assert property (cmd == CMD_REF && !cke |=> !cke)
		else $error("Clock enable rose right after self refresh entry.");
	chk_exit_with_nop: assert property ($rose(cke) |-> cs_n || cmd == CMD_NOP)
		else $error("Clock enable rose without a no-operation.");
	chk_cke_before_act: assert property (cmd == CMD_ACT
		|-> cke && $past(cke) && $past(cke, 2)) else $error("Activate too soon after wake.");
	chk_beats_in_burst: assert property (wstrobe |-> beats_r != 3'h0)
		else $error("Write beat outside a write burst.");
	chk_quiet_low_cke: assert property (!cke && !$past(cke) |-> cs_n || cmd == CMD_NOP)
		else $error("Command issued while clock enable was low.");
	chk_refresh_cke_prev: assert property (cmd == CMD_REF |-> $past(cke))
		else $error("Refresh decoded without clock enable high before.");
	cov_auto_refresh: cover property (cmd == CMD_REF && cke);
	cov_self_entry: cover property (cmd == CMD_REF && !cke);
	cov_masked_beat: cover property (wstrobe && write_mask);
	cov_write_ap: cover property (cmd == CMD_WRITE && addr[AUTO_PRECHARGE_FLAG_BIT]);
endmodule : dap_link_asserts

// ===== bench/tb_dram_autoprecharge_refresh_powerdown.sv
// Self-checking bench joining the controller end to the device end.
`timescale 1ns/1ns
module tb_dram_autoprecharge_refresh_powerdown
	import dap_pkg::*;
;
	logic                   clk_i           = 1'h0;
	logic                   resetn_i        = 1'h0;
	logic                   req_valid_i     = 1'h0;
	logic [2:0]             req_op_i        = 3'h0;
	logic [BANK_W-1:0]      req_bank_i      = '0;
	logic [ADDR_W-1:0]      req_addr_i      = '0;
	logic                   wd_valid_i      = 1'h0;
	logic [DATA_W-1:0]      wd_data_i       = '0;
	logic                   wd_mask_i       = 1'h0;
	logic [31:0]            rnd             = 32'hD92B;
	int                     mismatches      = 0;
	int                     samples_checked = 0;
	int                     cycles          = 0;
	logic                   req_ready_o, wd_ready_o, busy_o;
	logic                   self_refresh_o, power_down_o, cmd_error_o;
	logic [ADDR_W-1:0]      refresh_row_o;
	logic [3*NUM_BANKS-1:0] bank_state_o;
	logic [DATA_W:0]        notes[$];
	logic [DATA_W:0]        note;
	dap_link_if link ();
	dap_controller i_dap_controller (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i),
		.req_bank_i(req_bank_i), .req_addr_i(req_addr_i), .wd_valid_i(wd_valid_i),
		.wd_ready_o(wd_ready_o), .wd_data_i(wd_data_i), .wd_mask_i(wd_mask_i), .busy_o(busy_o));
	dap_device i_dap_device (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
		.refresh_row_o(refresh_row_o), .self_refresh_o(self_refresh_o),
		.power_down_o(power_down_o), .cmd_error_o(cmd_error_o), .bank_state_o(bank_state_o));
	dap_link_asserts i_dap_link_asserts (.clk_i(clk_i), .resetn_i(resetn_i), .cke(link.cke),
		.cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
		.ba(link.ba), .addr(link.addr), .write_mask(link.write_mask), .wstrobe(link.wstrobe));
	always #2 clk_i = ~clk_i;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	// Requests and words are held until ready is seen high ahead of the taking edge.
	task automatic request(input logic [2:0] op, input logic [BANK_W-1:0] b);
		@(negedge clk_i);
		rnd = xs(rnd);
		req_valid_i = 1'h1;
		req_op_i = op;
		req_bank_i = b;
		req_addr_i = rnd[ADDR_W-1:0];
		for (int n = 0; n < 400 && req_ready_o !== 1'h1; n++) @(negedge clk_i);
		@(posedge clk_i);
		@(negedge clk_i);
		req_valid_i = 1'h0;
	endtask : request
	task automatic words(input int lo, input int hi, input logic [3:0] mk);
		for (int i = lo; i < hi; i++) begin
			@(negedge clk_i);
			rnd = xs(rnd);
			wd_valid_i = 1'h1;
			wd_data_i = rnd[DATA_W-1:0];
			wd_mask_i = mk[i];
			for (int n = 0; n < 400 && wd_ready_o !== 1'h1; n++) @(negedge clk_i);
			@(posedge clk_i);
			notes.push_back({mk[i], wd_data_i});
		end
		@(negedge clk_i);
		wd_valid_i = 1'h0;
	endtask : words
	task automatic burst(input logic [2:0] op, input logic [BANK_W-1:0] b, input int lo,
		input logic [3:0] mk);
		fork
			request(op, b);
			words(lo, BURST_LENGTH, mk);
		join
	endtask : burst
	task automatic settle();
		for (int n = 0; n < 300 && busy_o !== 1'h0; n++) @(negedge clk_i);
		repeat (RAS_CYC) @(negedge clk_i);
	endtask : settle
	// Beat watcher, error watcher and hang limit share one clocked process.
	always @(posedge clk_i) begin
		cycles++;
		if (resetn_i && cmd_error_o !== 1'h0) begin
			mismatches++;
			$display("CHECK FAILED command error expected 0 seen %b", cmd_error_o);
		end
		if (resetn_i && link.wstrobe === 1'h1) begin
			note = notes.size() > 0 ? notes.pop_front() : '1;
			check("beat mask", 16'(note[DATA_W]), 16'(link.write_mask));
			if (note[DATA_W] === 1'h0) begin
				check("beat data", note[DATA_W-1:0], link.wdata);
			end
		end
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [BANK_W-1:0] bk;
		logic [3:0]        mk;
		repeat (20) @(negedge clk_i);
		resetn_i = 1'h1;
		// Back-to-back refreshes step the internal row and leave all banks idle.
		request(3'h2, 2'h3);
		request(3'h2, 2'h1);
		settle();
		check("refresh row", 16'h0002, 16'(refresh_row_o));
		check("banks idle", 16'h0249, 16'(bank_state_o));
		$display("Test auto refresh done");
		// The buffer is filled first, so a third word is refused until beats drain it.
		rnd = xs(rnd);
		bk = rnd[BANK_W-1:0];
		mk = rnd[7:4] | 4'h2;
		words(0, 2, mk);
		check("word ready", 16'h0000, 16'(wd_ready_o));
		burst(3'h1, bk, 2, mk);
		check("bank open", 16'h0002, 16'(bank_state_o[3*bk +: 3]));
		settle();
		check("bank closed", 16'h0001, 16'(bank_state_o[3*bk +: 3]));
		$display("Test write with auto precharge done");
		request(3'h3, 2'h0);
		settle();
		check("self refresh", 16'h0001, 16'(self_refresh_o));
		request(3'h5, 2'h0);
		settle();
		check("self exit", 16'h0000, 16'(self_refresh_o));
		$display("Test self refresh done");
		rnd = xs(rnd);
		bk = rnd[BANK_W-1:0];
		burst(3'h0, bk, 0, rnd[7:4]);
		settle();
		check("bank left open", 16'h0002, 16'(bank_state_o[3*bk +: 3]));
		request(3'h4, 2'h0);
		settle();
		check("power down", 16'h0001, 16'(power_down_o));
		check("open in power down", 16'h0002, 16'(bank_state_o[3*bk +: 3]));
		request(3'h5, 2'h0);
		settle();
		check("power up", 16'h0000, 16'(power_down_o));
		check("beats left", 16'h0000, 16'(notes.size()));
		$display("Test plain write and power down done");
		print_verdict();
	end
endmodule : tb_dram_autoprecharge_refresh_powerdown
